/* File: chrp_consts.svh */
/*
  constants of the host register port: special function register
  addresses, index register fields, reset values and buffer locations.
  assumes it is included by bare name from chrp_regmem, chrp_serial and chrp_port.
*/
`ifndef CHRP_CONSTS_SVH
`define CHRP_CONSTS_SVH

// special function register addresses on the cpu side
`define CHRP_ADDR_STATUS    8'hD8
`define CHRP_ADDR_COMMAND   8'hD9
`define CHRP_ADDR_WINDOW    8'hDA
`define CHRP_ADDR_INDEX     8'hDB

// index register fields
`define CHRP_IDX_XFER_BIT   7
`define CHRP_IDX_RSVD_BIT   6
`define CHRP_IDX_STEP_BIT   5
`define CHRP_IDX_SEL_MSB    4
`define CHRP_IDX_RESET      8'h64
`define CHRP_IDX_WRITE_MASK 8'hBF

// command port read: reserved bits high
`define CHRP_CMD_RSVD_MASK  8'hE0

// descriptor byte two fields
`define CHRP_DSC_REMOTE_BIT 4
`define CHRP_DSC_LEN_MSB    3

// internal buffer locations
`define CHRP_TX_BASE        5'h0A
`define CHRP_TX_DATA0       5'h0C
`define CHRP_RX_BASE        5'h14
`define CHRP_RX_DATA0       5'h16
`define CHRP_INT_REG        5'h03
`define CHRP_LAST_LOC       5'h1F

// memory geometry
`define CHRP_MEM_DEPTH      32
`define CHRP_MAX_BYTES      4'h8

`endif

/* File: chrp_pkg.sv */
/*
  types of the host register port.
  assumes chrp_consts.svh is on the include path.
*/
package chrp_pkg;
  // serialiser states, gray along idle -> load -> shift
  typedef enum logic [1:0] {
    CHRP_SER_IDLE  = 2'b00,
    CHRP_SER_LOAD  = 2'b01,
    CHRP_SER_SHIFT = 2'b11
  } chrp_ser_e;

  typedef logic [7:0] chrp_byte_t;
endpackage

/* File: chrp_regmem.sv */
/*
  controller internal register file: 32 bytes, one write and one read
  port, registered read data.
  assumes a single clock and synchronous active high reset.
*/
`timescale 1ns/100ps
`include "chrp_consts.svh"

module chrp_regmem
  import chrp_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       reset_in,
  // write port
  input  wire logic       wr_en_in,
  input  wire logic [4:0] wr_addr_in,
  input  wire chrp_byte_t wr_data_in,
  // read port
  input  wire logic [4:0] rd_addr_in,
  output chrp_byte_t      rd_data_out
);

  chrp_byte_t mem_q [`CHRP_MEM_DEPTH];
  chrp_byte_t rd_q;
  chrp_byte_t rd_d;

  // read data from a register so the window sees a stable value
  always_comb begin
    rd_d = mem_q[rd_addr_in];
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rd_q <= 8'h00;
    end else begin
      rd_q <= rd_d;
    end
  end

  // storage is not reset; software initialises the buffers
  always_ff @(posedge ref_clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  assign rd_data_out = rd_q;

endmodule // chrp_regmem

/* File: chrp_serial.sv */
/*
  data field serialiser: shifts data bytes msb first from the transmit
  buffer, starting at the first data location.
  assumes the caller supplies the byte count and returns registered
  memory data one cycle after the address; the next address is offered
  early so the first byte is already in the read register at load.
*/
`timescale 1ns/100ps
`include "chrp_consts.svh"

module chrp_serial
  import chrp_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       reset_in,
  // start and length
  input  wire logic       start_in,
  input  wire logic [3:0] count_in,
  // memory read side
  output logic [4:0]      addr_out,
  input  wire chrp_byte_t data_in,
  // serial output
  output logic            bit_out,
  output logic            bit_valid_out,
  output logic            busy_out
);

  chrp_ser_e  state_q, state_d;
  chrp_byte_t shreg_q, shreg_d;
  logic [2:0] bitn_q, bitn_d;
  logic [3:0] left_q, left_d;
  logic [4:0] addr_q, addr_d;

  // next state of the serialiser
  always_comb begin
    state_d = state_q;
    shreg_d = shreg_q;
    bitn_d  = bitn_q;
    left_d  = left_q;
    addr_d  = addr_q;
    unique case (state_q)
      CHRP_SER_IDLE: begin
        if (start_in && count_in != 4'h0) begin
          addr_d  = `CHRP_TX_DATA0;
          left_d  = count_in;
          state_d = CHRP_SER_LOAD;
        end
      end
      CHRP_SER_LOAD: begin
        shreg_d = data_in;
        bitn_d  = 3'h7;
        left_d  = left_q - 4'h1;
        addr_d  = addr_q + 5'h01;
        state_d = CHRP_SER_SHIFT;
      end
      CHRP_SER_SHIFT: begin
        shreg_d = {shreg_q[6:0], 1'b0};
        bitn_d  = bitn_q - 3'h1;
        if (bitn_q == 3'h0) begin
          state_d = (left_q == 4'h0) ? CHRP_SER_IDLE : CHRP_SER_LOAD;
        end
      end
      default: state_d = CHRP_SER_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state_q <= CHRP_SER_IDLE;
      shreg_q <= 8'h00;
      bitn_q  <= 3'h0;
      left_q  <= 4'h0;
      addr_q  <= 5'h00;
    end else begin
      state_q <= state_d;
      shreg_q <= shreg_d;
      bitn_q  <= bitn_d;
      left_q  <= left_d;
      addr_q  <= addr_d;
    end
  end

  // next address, so the registered read lines up with the load step
  assign addr_out      = addr_d;
  assign bit_out       = shreg_q[7];
  assign bit_valid_out = (state_q == CHRP_SER_SHIFT);
  assign busy_out      = (state_q != CHRP_SER_IDLE);

endmodule // chrp_serial

/* File: chrp_port.sv */
/*
  host register port of the can controller: index, data window,
  command/interrupt port and status/ram pointer port, plus decoding of
  the transmit descriptor into frame type and byte count.
  assumes cpu strobes are single-cycle on ref_clk_in, and that the
  protocol engine drives flags and status levels on the same clock.
*/
`timescale 1ns/100ps
`include "chrp_consts.svh"

module chrp_port
  import chrp_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       reset_in,
  // cpu special function register access
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic       sfr_rd_in,
  input  wire logic       sfr_wr_in,
  input  wire logic [7:0] sfr_wdata_in,
  output logic [7:0]      sfr_rdata_out,
  // controller state from the protocol engine
  input  wire logic [4:0] irq_flags_in,
  input  wire logic [7:0] ctrl_status_in,
  // command register toward the protocol engine
  output logic [7:0]      command_out,
  output logic            command_stb_out,
  // block transfer engine handshake
  output logic [7:0]      ram_pointer_out,
  output logic            xfer_start_out,
  input  wire logic       xfer_done_in,
  // frame set-up derived from the transmit descriptor
  input  wire logic       send_start_in,
  output logic            remote_frame_out,
  output logic [3:0]      byte_count_out,
  output logic [4:0]      rx_data_base_out,
  output logic            tx_bit_out,
  output logic            tx_bit_valid_out,
  output logic            tx_busy_out
);

  //////////////////////////////////////////////////////////////////////////
  // cpu decode

  logic hit_sta, hit_cmd, hit_win, hit_idx;
  assign hit_sta = (sfr_addr_in == `CHRP_ADDR_STATUS);
  assign hit_cmd = (sfr_addr_in == `CHRP_ADDR_COMMAND);
  assign hit_win = (sfr_addr_in == `CHRP_ADDR_WINDOW);
  assign hit_idx = (sfr_addr_in == `CHRP_ADDR_INDEX);

  //////////////////////////////////////////////////////////////////////////
  // host registers

  chrp_byte_t index_q, index_d;
  chrp_byte_t cmd_q, cmd_d;
  chrp_byte_t ramp_q, ramp_d;
  chrp_byte_t dscr_q, dscr_d;
  logic       cstb_q, cstb_d;
  logic       xstart_q, xstart_d;
  logic       win_acc;
  logic [4:0] sel;

  assign sel     = index_q[`CHRP_IDX_SEL_MSB:0];
  assign win_acc = hit_win && (sfr_rd_in || sfr_wr_in);

  // index, command, pointer and descriptor shadow next values
  always_comb begin
    index_d  = index_q;
    cmd_d    = cmd_q;
    ramp_d   = ramp_q;
    dscr_d   = dscr_q;
    cstb_d   = 1'b0;
    xstart_d = 1'b0;
    if (xfer_done_in) begin
      index_d[`CHRP_IDX_XFER_BIT] = 1'b0;
    end
    if (sfr_wr_in && hit_idx) begin
      // bit 6 written as zero so it cannot steer anything
      index_d = sfr_wdata_in & `CHRP_IDX_WRITE_MASK;
      xstart_d = sfr_wdata_in[`CHRP_IDX_XFER_BIT];
    end else if (win_acc && index_q[`CHRP_IDX_STEP_BIT]) begin
      // stepping past the last location drops auto step mode
      if (sel == `CHRP_LAST_LOC) begin
        index_d[`CHRP_IDX_STEP_BIT] = 1'b0;
      end
      index_d[`CHRP_IDX_SEL_MSB:0] = sel + 5'h01;
    end
    if (sfr_wr_in && hit_cmd) begin
      cmd_d  = sfr_wdata_in;
      cstb_d = 1'b1;
    end
    if (sfr_wr_in && hit_sta) begin
      ramp_d = sfr_wdata_in;
    end
    if (sfr_wr_in && hit_win && sel == `CHRP_TX_BASE + 5'h01) begin
      dscr_d = sfr_wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      index_q  <= `CHRP_IDX_RESET;
      cmd_q    <= 8'h00;
      ramp_q   <= 8'h00;
      dscr_q   <= 8'h00;
      cstb_q   <= 1'b0;
      xstart_q <= 1'b0;
    end else begin
      index_q  <= index_d;
      cmd_q    <= cmd_d;
      ramp_q   <= ramp_d;
      dscr_q   <= dscr_d;
      cstb_q   <= cstb_d;
      xstart_q <= xstart_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // internal register file and serialiser share one read port

  chrp_byte_t mem_rdata;
  logic [4:0] ser_addr;
  logic [4:0] rd_addr;
  logic       ser_busy;

  // serialiser owns the read port from its start strobe on, so the
  // first data byte is fetched before the load step; cpu must wait
  assign rd_addr = (ser_busy || send_start_in) ? ser_addr : sel;

  chrp_regmem u_mem (
    .ref_clk_in  (ref_clk_in),
    .reset_in    (reset_in),
    .wr_en_in    (sfr_wr_in && hit_win),
    .wr_addr_in  (sel),
    .wr_data_in  (sfr_wdata_in),
    .rd_addr_in  (rd_addr),
    .rd_data_out (mem_rdata)
  );

  //////////////////////////////////////////////////////////////////////////
  // descriptor decode

  logic       remote;
  logic [3:0] len_code;
  logic [3:0] count;

  assign remote   = dscr_q[`CHRP_DSC_REMOTE_BIT];
  assign len_code = dscr_q[`CHRP_DSC_LEN_MSB:0];
  // plain binary weighting 8/4/2/1; remote frames carry no data
  assign count    = remote ? 4'h0 : len_code;

  chrp_serial u_ser (
    .ref_clk_in    (ref_clk_in),
    .reset_in      (reset_in),
    .start_in      (send_start_in),
    .count_in      (count),
    .addr_out      (ser_addr),
    .data_in       (mem_rdata),
    .bit_out       (tx_bit_out),
    .bit_valid_out (tx_bit_valid_out),
    .busy_out      (ser_busy)
  );

  //////////////////////////////////////////////////////////////////////////
  // cpu read mux: read and write of command/status differ

  chrp_byte_t rdata_q, rdata_d;

  // registered read data, valid the cycle after the read strobe
  always_comb begin
    rdata_d = rdata_q;
    if (sfr_rd_in) begin
      unique case (1'b1)
        hit_cmd: rdata_d = `CHRP_CMD_RSVD_MASK | {3'h0, irq_flags_in};
        hit_sta: rdata_d = ctrl_status_in;
        hit_win: rdata_d = mem_rdata;
        // reserved bit 6 always reads high
        hit_idx: rdata_d = index_q | 8'h40;
        default: rdata_d = 8'hFF;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  assign sfr_rdata_out    = rdata_q;
  assign command_out      = cmd_q;
  assign command_stb_out  = cstb_q;
  assign ram_pointer_out  = ramp_q;
  assign xfer_start_out   = xstart_q;
  assign remote_frame_out = remote;
  assign byte_count_out   = count;
  assign rx_data_base_out = `CHRP_RX_DATA0;
  assign tx_busy_out      = ser_busy;

endmodule // chrp_port

/* File: chrp_port_asserts.sv */
/*
  checker of the host register port, bound to chrp_port.
  assumes single clock, synchronous active high reset.
*/
`timescale 1ns/100ps
module chrp_port_asserts (
  // clock and reset
  input wire logic       ref_clk_in,
  input wire logic       reset_in,
  // cpu side
  input wire logic [7:0] sfr_addr_in,
  input wire logic       sfr_rd_in,
  input wire logic       sfr_wr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [7:0] sfr_rdata_out,
  // engine side
  input wire logic [4:0] irq_flags_in,
  input wire logic [7:0] ctrl_status_in,
  input wire logic [7:0] command_out,
  input wire logic       command_stb_out,
  input wire logic [7:0] ram_pointer_out,
  input wire logic       xfer_start_out,
  input wire logic       send_start_in,
  input wire logic       remote_frame_out,
  input wire logic [3:0] byte_count_out,
  input wire logic [4:0] rx_data_base_out,
  input wire logic       tx_bit_valid_out,
  input wire logic       tx_busy_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  //////////////////////////////////////////////////////////////////////
  // serial start and one byte of valid bits
  sequence s_go;
    send_start_in && !tx_busy_out && byte_count_out != 4'h0;
  endsequence
  sequence s_byte;
    tx_bit_valid_out [*8];
  endsequence
  AST_SER_BYTE: assert property (s_go |-> ##2 s_byte)
    else $error("serial byte not sent in eight cycles");
  AST_REMOTE_ZERO: assert property (remote_frame_out |-> byte_count_out == 4'h0)
    else $error("remote frame with nonzero count");
  AST_RX_BASE: assert property (rx_data_base_out == 5'h16)
    else $error("receive data base wrong");
  AST_CMD_WR: assert property (sfr_wr_in && sfr_addr_in == 8'hD9 |=>
    command_stb_out && command_out == $past(sfr_wdata_in))
    else $error("command write not loaded");
  AST_PTR_WR: assert property (sfr_wr_in && sfr_addr_in == 8'hD8 |=>
    ram_pointer_out == $past(sfr_wdata_in))
    else $error("ram pointer not loaded");
  AST_XFER: assert property (sfr_wr_in && sfr_addr_in == 8'hDB
    && sfr_wdata_in[7] |=> xfer_start_out)
    else $error("transfer start missing");
  AST_CMD_RD: assert property (sfr_rd_in && sfr_addr_in == 8'hD9 |=>
    sfr_rdata_out == {3'b111, $past(irq_flags_in)})
    else $error("flag read wrong");
  AST_STA_RD: assert property (sfr_rd_in && sfr_addr_in == 8'hD8 |=>
    sfr_rdata_out == $past(ctrl_status_in))
    else $error("status read wrong");
  AST_IDX_RSVD: assert property (sfr_rd_in && sfr_addr_in == 8'hDB |=>
    sfr_rdata_out[6])
    else $error("reserved index bit reads low");
endmodule // chrp_port_asserts

/* File: chrp_cpu_model.sv */
/*
  cpu core model: single-cycle sfr read and write strobes.
  assumes read data is settled one cycle after the read edge.
*/
`timescale 1ns/100ps
module chrp_cpu_model (
  // clock and read data
  input  wire logic       ref_clk_in,
  input  wire logic [7:0] sfr_rdata_in,
  // sfr strobes
  output logic [7:0]      sfr_addr_out,
  output logic            sfr_rd_out,
  output logic            sfr_wr_out,
  output logic [7:0]      sfr_wdata_out
);
  initial begin
    sfr_addr_out  = 8'h00;
    sfr_rd_out    = 1'b0;
    sfr_wr_out    = 1'b0;
    sfr_wdata_out = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////
  // idle bus shows inverted values so stale data never looks valid
  // writes are plain stores, never read-modify-write on any port
  task automatic wr_sfr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    #1 sfr_addr_out = a;
    sfr_wdata_out = d;
    sfr_wr_out = 1'b1;
    @(posedge ref_clk_in);
    #1 sfr_wr_out = 1'b0;
    sfr_addr_out = ~a;
    sfr_wdata_out = ~d;
  endtask
  task automatic rd_sfr(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    #1 sfr_addr_out = a;
    sfr_rd_out = 1'b1;
    @(posedge ref_clk_in);
    #1 sfr_rd_out = 1'b0;
    sfr_addr_out = ~a;
    @(posedge ref_clk_in);
    d = sfr_rdata_in;
  endtask
endmodule // chrp_cpu_model

/* File: tb.sv */
/*
  testbench of chrp_port with cpu model and checker.
  assumes a 100 ns clock and engine inputs driven from here.
*/
`timescale 1ns/100ps
module tb;
  logic       clk = 1'b0, rst = 1'b1, rd, wr, xdone = 1'b0, go = 1'b0;
  logic [7:0] addr, wdata, rdata, cmd, ptr, status = 8'h00, d;
  logic [4:0] flags = 5'h00, rxb;
  logic [3:0] cnt;
  logic       remote, xstart, tbit, tvalid, tbusy, cstb;
  int         err_count = 0, cmp_count = 0;
  initial forever #50 clk = ~clk;
  chrp_cpu_model i_chrp_cpu_model (.ref_clk_in(clk), .sfr_rdata_in(rdata),
    .sfr_addr_out(addr), .sfr_rd_out(rd), .sfr_wr_out(wr),
    .sfr_wdata_out(wdata));
  chrp_port i_chrp_port (.ref_clk_in(clk), .reset_in(rst),
    .sfr_addr_in(addr), .sfr_rd_in(rd), .sfr_wr_in(wr),
    .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .irq_flags_in(flags),
    .ctrl_status_in(status), .command_out(cmd), .command_stb_out(cstb),
    .ram_pointer_out(ptr), .xfer_start_out(xstart), .xfer_done_in(xdone),
    .send_start_in(go), .remote_frame_out(remote), .byte_count_out(cnt),
    .rx_data_base_out(rxb), .tx_bit_out(tbit), .tx_bit_valid_out(tvalid),
    .tx_busy_out(tbusy));
  //////////////////////////////////////////////////////////////////////
  // comparison and verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("compares=%0d errors=%0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr_(input logic [7:0] a, input logic [7:0] v);
    i_chrp_cpu_model.wr_sfr(a, v);
  endtask
  task automatic rd_(input logic [7:0] a, input logic [7:0] exp);
    i_chrp_cpu_model.rd_sfr(a, d);
    chk(d, exp);
  endtask
  //////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_index();
    rd_(8'hDB, 8'h64);
    wr_(8'hDB, 8'h83);
    rd_(8'hDB, 8'hC3);
    @(posedge clk) #1 xdone = 1'b1;
    @(posedge clk) #1 xdone = 1'b0;
    rd_(8'hDB, 8'h43);
  endtask
  task automatic t_window();
    wr_(8'hDB, 8'h2A);
    wr_(8'hDA, 8'h11);
    wr_(8'hDA, 8'h02);
    wr_(8'hDA, 8'h81);
    wr_(8'hDA, 8'h3C);
    rd_(8'hDB, 8'h6E);
    wr_(8'hDB, 8'h0A);
    rd_(8'hDA, 8'h11);
    wr_(8'hDB, 8'h0D);
    rd_(8'hDA, 8'h3C);
    wr_(8'hDB, 8'h3F);
    wr_(8'hDA, 8'h00);
    rd_(8'hDB, 8'h40);
  endtask
  task automatic t_serial();
    logic [15:0] bits;
    bits = 16'h0000;
    @(posedge clk) #1 go = 1'b1;
    @(posedge clk) #1 go = 1'b0;
    repeat (40) @(posedge clk) if (tvalid === 1'b1) bits = {bits[14:0], tbit};
    chk(bits, 16'h813C);
    chk(tbusy, 1'b0);
  endtask
  task automatic t_length();
    wr_(8'hDB, 8'h0B);
    // host keeps to byte counts zero to eight
    for (int k = 0; k < 9; k++) begin
      wr_(8'hDA, k[7:0]);
      chk({remote, cnt}, {1'b0, k[3:0]});
    end
    // remote frame with length code eight reports a byte count of zero
    wr_(8'hDA, 8'h18);
    chk({remote, cnt}, 5'h10);
  endtask
  task automatic t_ports();
    flags = 5'h15;
    status = 8'hA6;
    rd_(8'hD9, 8'hF5);
    rd_(8'hD8, 8'hA6);
    wr_(8'hD9, 8'h5A);
    chk(cmd, 8'h5A);
    rd_(8'hD9, 8'hF5);
    wr_(8'hD8, 8'h77);
    chk(ptr, 8'h77);
    rd_(8'hD8, 8'hA6);
    rd_(8'h55, 8'hFF);
    chk(rxb, 5'h16);
  endtask
  task automatic t_reset();
    @(posedge clk) #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    rd_(8'hDB, 8'h64);
    chk(cmd, 8'h00);
  endtask
  //////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    t_index();
    t_window();
    t_serial();
    t_length();
    t_ports();
    t_reset();
    finish_test();
  end
  initial begin
    #2000000;
    err_count++;
    finish_test();
  end
endmodule // tb
bind chrp_port chrp_port_asserts i_chrp_port_asserts (
  .ref_clk_in(ref_clk_in), .reset_in(reset_in), .sfr_addr_in(sfr_addr_in),
  .sfr_rd_in(sfr_rd_in), .sfr_wr_in(sfr_wr_in),
  .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
  .irq_flags_in(irq_flags_in), .ctrl_status_in(ctrl_status_in),
  .command_out(command_out), .command_stb_out(command_stb_out),
  .ram_pointer_out(ram_pointer_out), .xfer_start_out(xfer_start_out),
  .send_start_in(send_start_in), .remote_frame_out(remote_frame_out),
  .byte_count_out(byte_count_out), .rx_data_base_out(rx_data_base_out),
  .tx_bit_valid_out(tx_bit_valid_out), .tx_busy_out(tx_busy_out));
